//--- bench/abec_link_sva.sv
`timescale 1ns/1ps
module abec_link_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        req,
  input wire logic        we,
  input wire logic [2:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        ack,
  input wire logic [31:0] rdata,
  input wire logic        err_irq
);
  import abec_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // answer of a read on the link
  // ----------------------------------------------------------------
  sequence s_rd(idx);
    ack && !$past(we) && $past(addr) == idx;
  endsequence
  sequence s_rd_void;
    ack && !$past(we) && $past(addr) > 3'h5;
  endsequence
  a_ack_has_req: assert property (ack |-> $past(req) && !$past(ack))
    else $error("ack without request");
  a_ack_single: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_req_off_ack: assert property (ack |-> !req)
    else $error("request held during ack");
  a_req_hold: assert property (req ##1 req |-> $stable(addr) && $stable(we) && $stable(wdata))
    else $error("request fields changed while waiting");
  // node reset stalls acks for a while, hence the wide bound
  a_ack_bounded: assert property ($rose(req) |-> ##[1:40] ack)
    else $error("request never acknowledged");
  a_summary_or: assert property (s_rd(IDX_BER) |-> rdata[BER_SUMMARY] == |(rdata & BER_FLAGS))
    else $error("summary bit disagrees with flags");
  a_nreset_zero: assert property (s_rd(IDX_BER) |-> !rdata[BER_NRESET])
    else $error("node reset bit reads back set");
  a_void_zero: assert property (s_rd_void |-> rdata == 32'h0000_0000)
    else $error("unmapped index read not zero");
  a_irq_masked: assert property (s_rd(IDX_CTRL) ##0 !rdata[0] |-> ##1 !err_irq)
    else $error("error interrupt while disabled");
endmodule

//--- bench/adapter_bus_error_capture_tb_top.sv
`timescale 1ns/1ps
module adapter_bus_error_capture_tb_top;
  import abec_pkg::*;
  localparam int RXC = 20;
  localparam int TXC = 10;
  localparam int FBIT [0:8] = '{BER_PAR, BER_WSEQ, BER_RDNAK, BER_WDNAK, BER_NORSP,
                                BER_RSEQ, BER_RERSP, BER_CMDNAK, BER_TMO};
  localparam logic [3:0] FST [0:8] = '{4'h0, 4'h0, 4'h0, 4'h0, ST_NORSP,
                                       4'h0, ST_RERSP, ST_CMDNAK, ST_TMO};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, d1, pdo, pdt, bootad;
  logic pready, pslverr, err_irq, last_err, bus_noack, dm_wr, halt, rst_p, cerr, nmi;
  logic memerr, rxp, txen, rxen, nrst, pinit;
  logic [3:0]  dms;
  logic [7:0]  rcode;
  logic [8:0]  ev = 9'h000;
  logic pf = 0, gto = 0, lpar = 0, lmas = 0, rxw = 0, txw = 0, lrst = 0;
  logic halt_seen = 0, nrst_seen = 0;
  logic [63:0] q_rd [$];
  logic [3:0]  q_dm [$];
  logic [63:0] note;
  logic [31:0] lfsr = 32'h0000_0045;
  int n_fail = 0, check_count = 0, n_rst = 0, n_init = 0, n_part = 0;

  always #10 pclk = ~pclk;

  abec_if abec_if_i ();
  abec_host abec_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lnk(abec_if_i), .err_irq(err_irq));
  abec_device #(.RX_CYC(RXC), .TX_CYC(TXC)) abec_device_i (.pclk(pclk), .presetn(presetn),
    .lnk(abec_if_i), .ev_parity(ev[0]), .ev_wr_seq(ev[1]), .ev_rd_data_noack(ev[2]),
    .ev_wr_data_noack(ev[3]), .ev_no_rd_rsp(ev[4]), .ev_rd_seq(ev[5]), .ev_rd_err_rsp(ev[6]),
    .ev_cmd_noack(ev[7]), .ev_timeout(ev[8]), .bus_noack(bus_noack), .dm_status_wr(dm_wr),
    .dm_status(dms), .cpu_halt(halt), .cpu_restart(rst_p), .cpu_restart_code(rcode),
    .cpu_boot_addr(bootad), .cpu_err(cerr), .cpu_nmi(nmi), .power_fail(pf),
    .grant_timeout(gto), .local_parity_err(lpar), .lan_is_master(lmas), .rx_dma_wait(rxw),
    .tx_dma_wait(txw), .lan_restart(lrst), .lan_mem_err(memerr), .rx_partial(rxp),
    .tx_enable(txen), .rx_enable(rxen), .node_resetting(nrst), .port_init(pinit),
    .port_data_one(pdo), .port_data_two(pdt));
  abec_link_sva abec_link_sva_i (.pclk(pclk), .presetn(presetn), .req(abec_if_i.req),
    .we(abec_if_i.we), .addr(abec_if_i.addr), .wdata(abec_if_i.wdata), .ack(abec_if_i.ack),
    .rdata(abec_if_i.rdata), .err_irq(abec_if_i.err_irq));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic results();
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready ends this wait; the host ties it high, so it lasts one cycle
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    q_rd.push_back({m, e});
    apb(1'b0, a, 32'h0);
  endtask
  // busy polling keeps the link ordering; masked notes keep the queue aligned
  task automatic cmd(input logic [2:0] idx, input logic w, input abec_op_e op);
    int n;
    apb(1'b1, HA_CMD, {26'h0, op, w, idx});
    n = 0;
    do begin
      rdc(HA_STAT, 32'h0, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 100);
    chk("busy", 32'h0, {31'h0, rd[0]});
  endtask
  task automatic raw_rd(input logic [2:0] i, input logic [31:0] m, input logic [31:0] e);
    cmd(i, 1'b0, OP_RAW);
    rdc(HA_RDATA, m, e);
  endtask
  task automatic raw_wr(input logic [2:0] i, input logic [31:0] d);
    apb(1'b1, HA_WDATA, d);
    cmd(i, 1'b1, OP_RAW);
  endtask
  task automatic pulse(input int i);
    @(posedge pclk);
    ev <= 9'h001 << i;
    if (FST[i] != 4'h0) q_dm.push_back(FST[i]);
    #1 chk("bus_noack", {31'h0, i < 2}, bus_noack);
    @(posedge pclk);
    ev <= 9'h000;
  endtask
  task automatic lan_go();
    @(posedge pclk);
    lrst <= 1;
    @(posedge pclk);
    lrst <= 0;
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && q_rd.size() > 0) begin
      note = q_rd.pop_front();
      chk("prdata", note[31:0], prdata & note[63:32]);
    end
    if (dm_wr === 1'b1) begin
      if (q_dm.size() > 0) chk("dm_status", q_dm.pop_front(), dms);
      else chk("dm_status_wr", 32'h0, 32'h1);
    end
    if (rst_p === 1'b1) n_rst++;
    if (pinit === 1'b1) n_init++;
    if (rxp === 1'b1) n_part++;
    if (halt === 1'b1) halt_seen <= 1;
    if (nrst === 1'b1) nrst_seen <= 1;
  end

  initial begin
    #400000;
    n_fail++;
    results();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    chk("en", 32'h3, {30'h0, txen, rxen});
    chk("nmi", 32'h0, nmi);
    raw_rd(IDX_BER, 32'hffff_ffff, BER_RESET);
    raw_wr(IDX_CTRL, 32'h1);
    for (int i = 0; i < 9; i++) begin
      pulse(i);
      raw_rd(IDX_BER, 32'h8000_0000 | BER_FLAGS, 32'h8000_0000 | (32'h1 << FBIT[i]));
      rdc(HA_STAT, 32'h2, 32'h2);
      chk("err_irq", 32'h1, err_irq);
      raw_wr(IDX_BER, 32'h1 << FBIT[i]);
      raw_rd(IDX_BER, 32'h8000_0000 | BER_FLAGS, 32'h0);
      chk("err_irq", 32'h0, err_irq);
    end
    raw_wr(IDX_CTRL, 32'h0);
    raw_rd(IDX_CTRL, 32'h1, 32'h0);
    pulse(8);
    raw_rd(IDX_BER, 32'h8000_0000, 32'h8000_0000);
    chk("err_irq", 32'h0, err_irq);
    @(posedge pclk);
    gto <= 1;
    @(posedge pclk);
    gto <= 0;
    raw_rd(IDX_DIAG, 32'h1, 32'h1);
    chk("cpu_err", 32'h1, cerr);
    for (int k = 1; k < 4; k++) begin
      lfsr = nxt(lfsr);
      d1 = lfsr;
      apb(1'b1, HA_PD1, d1);
      lfsr = nxt(lfsr);
      apb(1'b1, HA_PD2, lfsr);
      cmd(3'h0, 1'b0, abec_op_e'(k));
      chk("pd1", d1, pdo);
      chk("pd2", lfsr, pdt);
      chk("n_init", k, n_init);
      chk("halt", 32'h0, halt);
    end
    chk("halt_seen", 32'h1, halt_seen);
    chk("n_rst", 32'h1, n_rst);
    chk("code", RESTART_CODE, rcode);
    chk("boot", BOOT_ADDR, bootad);
    chk("nrst_seen", 32'h1, nrst_seen);
    chk("cpu_err", 32'h0, cerr);
    rdc(HA_CMD, 32'h3f, {26'h0, OP_INIT, 4'h0});
    rdc(HA_PD2, 32'hffff_ffff, lfsr);
    raw_rd(IDX_BER, 32'hffff_ffff, 32'h0);
    raw_rd(IDX_PD1, 32'hffff_ffff, d1);
    @(posedge pclk);
    lpar <= 1;
    #1 chk("mem_err", 32'h0, memerr);
    @(posedge pclk);
    lmas <= 1;
    #1 chk("mem_err", 32'h1, memerr);
    @(posedge pclk);
    lpar <= 0;
    lmas <= 0;
    #1 chk("en", 32'h0, {30'h0, txen, rxen});
    raw_rd(IDX_DIAG, 32'h6, 32'h6);
    lan_go();
    #1 chk("en", 32'h3, {30'h0, txen, rxen});
    @(posedge pclk);
    txw <= 1;
    repeat (TXC + 5) @(posedge pclk);
    txw <= 0;
    #1 chk("en", 32'h1, {30'h0, txen, rxen});
    raw_rd(IDX_DIAG, 32'h6, 32'h2);
    lan_go();
    @(posedge pclk);
    rxw <= 1;
    repeat (RXC + 5) @(posedge pclk);
    rxw <= 0;
    @(posedge pclk);
    pf <= 1'b1;
    #1 chk("n_part", 32'h1, n_part);
    chk("en", 32'h3, {30'h0, txen, rxen});
    chk("nmi", 32'h1, nmi);
    rdc(8'h20, 32'hffff_ffff, 32'h0);
    chk("pslverr", 32'h1, last_err);
    raw_rd(3'h7, 32'hffff_ffff, 32'h0);
    chk("q_dm", 32'h0, q_dm.size());
    results();
  end
endmodule

//--- rtl/abec_device.sv
`timescale 1ns/1ps
module abec_device
  import abec_pkg::*;
#(
  parameter int RX_CYC = abec_pkg::RX_LAT_CYC,
  parameter int TX_CYC = abec_pkg::TX_LAT_CYC
) (
  input  wire logic  pclk,
  input  wire logic  presetn,
  abec_if.dev        lnk,
  input  wire logic  ev_parity,
  input  wire logic  ev_wr_seq,
  input  wire logic  ev_rd_data_noack,
  input  wire logic  ev_wr_data_noack,
  input  wire logic  ev_no_rd_rsp,
  input  wire logic  ev_rd_seq,
  input  wire logic  ev_rd_err_rsp,
  input  wire logic  ev_cmd_noack,
  input  wire logic  ev_timeout,
  output logic       bus_noack,
  output logic       dm_status_wr,
  output logic [3:0] dm_status,
  output logic       cpu_halt,
  output logic       cpu_restart,
  output logic [7:0] cpu_restart_code,
  output logic [31:0] cpu_boot_addr,
  output logic       cpu_err,
  output logic       cpu_nmi,
  input  wire logic  power_fail,
  input  wire logic  grant_timeout,
  input  wire logic  local_parity_err,
  input  wire logic  lan_is_master,
  input  wire logic  rx_dma_wait,
  input  wire logic  tx_dma_wait,
  input  wire logic  lan_restart,
  output logic       lan_mem_err,
  output logic       rx_partial,
  output logic       tx_enable,
  output logic       rx_enable,
  output logic       node_resetting,
  output logic       port_init,
  output logic [31:0] port_data_one,
  output logic [31:0] port_data_two
);
  import abec_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] ber_r,  ber_nxt;
  logic [31:0] pd1_r,  pd1_nxt;
  logic [31:0] pd2_r,  pd2_nxt;
  logic        ien_r,  ien_nxt;
  logic        gto_r,  gto_nxt;
  logic        txs_r,  txs_nxt;
  logic        rxs_r,  rxs_nxt;
  logic        ack_r,  ack_nxt;
  logic [31:0] rd_r,   rd_nxt;
  logic        init_r, init_nxt;
  logic        hlt_d_r;
  logic        rst_r,  rst_nxt;
  logic [4:0]  rcnt_r, rcnt_nxt;
  logic [15:0] rxc_r,  rxc_nxt;
  logic [15:0] txc_r,  txc_nxt;
  logic        rxp_r,  rxp_nxt;
  logic        sw_r,   sw_nxt;
  logic [3:0]  st_r,   st_nxt;
  logic        mem_err;
  logic        wr;
  logic [31:0] set_v;

  assign wr      = lnk.req & lnk.we & ~ack_r & ~rst_r;
  // lan sees a memory error when local parity trips under its mastership
  assign mem_err = local_parity_err & lan_is_master;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    set_v            = '0;
    set_v[BER_PAR]   = ev_parity;
    set_v[BER_WSEQ]  = ev_wr_seq;
    set_v[BER_RDNAK] = ev_rd_data_noack;
    set_v[BER_WDNAK] = ev_wr_data_noack;
    set_v[BER_NORSP] = ev_no_rd_rsp;
    set_v[BER_RSEQ]  = ev_rd_seq;
    set_v[BER_RERSP] = ev_rd_err_rsp;
    set_v[BER_CMDNAK] = ev_cmd_noack;
    set_v[BER_TMO]   = ev_timeout;
    ber_nxt  = ber_r;
    pd1_nxt  = pd1_r;
    pd2_nxt  = pd2_r;
    ien_nxt  = ien_r;
    init_nxt = 1'b0;
    ack_nxt  = 1'b0;
    rd_nxt   = rd_r;
    rst_nxt  = rst_r;
    rcnt_nxt = rcnt_r;
    // host accesses: one-cycle ack, stalled while the node resets
    if (lnk.req & ~ack_r & ~rst_r) begin
      ack_nxt = 1'b1;
      case (lnk.addr)
        IDX_BER:  rd_nxt = ber_r;
        IDX_PD1:  rd_nxt = pd1_r;
        IDX_PD2:  rd_nxt = pd2_r;
        IDX_DIAG: rd_nxt = {29'h0, rxs_r, txs_r, gto_r};
        IDX_CTRL: rd_nxt = {31'h0, ien_r};
        default:  rd_nxt = 32'h0;
      endcase
    end
    if (wr) begin
      case (lnk.addr)
        IDX_BER: begin
          ber_nxt[BER_HALT] = lnk.wdata[BER_HALT];
          ber_nxt = ber_nxt & ~(lnk.wdata & BER_FLAGS);
          rst_nxt = lnk.wdata[BER_NRESET];
        end
        IDX_PINIT: init_nxt = 1'b1;
        IDX_PD1:   pd1_nxt = lnk.wdata;
        IDX_PD2:   pd2_nxt = lnk.wdata;
        IDX_CTRL:  ien_nxt = lnk.wdata[0];
        default:   ;
      endcase
    end
    // set after clear so an event in the clearing cycle is kept
    ber_nxt = ber_nxt | set_v;
    ber_nxt[BER_SUMMARY] = |(ber_nxt & BER_FLAGS);
    // node reset: bus error, port data and irq enable back to power-up values for a while
    if (rst_r) begin
      rcnt_nxt = rcnt_r + 5'h1;
      ber_nxt  = BER_RESET;
      pd1_nxt  = '0;
      pd2_nxt  = '0;
      ien_nxt  = 1'b0;
      if (rcnt_r == 5'(RESET_CYC - 1)) begin
        rst_nxt  = 1'b0;
        rcnt_nxt = '0;
      end
    end
  end

  // lan side: latency watchdogs and shutdowns
  always_comb begin
    gto_nxt = gto_r | grant_timeout;
    rxp_nxt = 1'b0;
    rxc_nxt = rx_dma_wait ? rxc_r : '0;
    txc_nxt = tx_dma_wait ? txc_r : '0;
    txs_nxt = txs_r;
    rxs_nxt = rxs_r;
    if (rx_dma_wait & (rxc_r <= 16'(RX_CYC)))
      rxc_nxt = rxc_r + 16'h1;
    if (tx_dma_wait & (txc_r <= 16'(TX_CYC)))
      txc_nxt = txc_r + 16'h1;
    // rx overflow only loses the packet; both directions keep running
    if (rx_dma_wait & (rxc_r == 16'(RX_CYC)))
      rxp_nxt = 1'b1;
    if (lan_restart) begin
      txs_nxt = 1'b0;
      rxs_nxt = 1'b0;
    end
    if (tx_dma_wait & (txc_r == 16'(TX_CYC)))
      txs_nxt = 1'b1;
    if (mem_err) begin
      txs_nxt = 1'b1;
      rxs_nxt = 1'b1;
    end
    if (rst_r) begin
      gto_nxt = 1'b0;
      txs_nxt = 1'b0;
      rxs_nxt = 1'b0;
    end
    // status to datamove/peek; timeout outranks the others
    sw_nxt = 1'b1;
    st_nxt = st_r;
    if (ev_timeout)         st_nxt = ST_TMO;
    else if (ev_cmd_noack)  st_nxt = ST_CMDNAK;
    else if (ev_rd_err_rsp) st_nxt = ST_RERSP;
    else if (ev_no_rd_rsp)  st_nxt = ST_NORSP;
    else                    sw_nxt = 1'b0;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ber_r   <= BER_RESET;
      pd1_r   <= '0;
      pd2_r   <= '0;
      ien_r   <= 1'b0;
      gto_r   <= 1'b0;
      txs_r   <= 1'b0;
      rxs_r   <= 1'b0;
      ack_r   <= 1'b0;
      rd_r    <= '0;
      init_r  <= 1'b0;
      hlt_d_r <= 1'b0;
      rst_r   <= 1'b0;
      rcnt_r  <= '0;
      rxc_r   <= '0;
      txc_r   <= '0;
      rxp_r   <= 1'b0;
      sw_r    <= 1'b0;
      st_r    <= '0;
    end else begin
      ber_r   <= ber_nxt;
      pd1_r   <= pd1_nxt;
      pd2_r   <= pd2_nxt;
      ien_r   <= ien_nxt;
      gto_r   <= gto_nxt;
      txs_r   <= txs_nxt;
      rxs_r   <= rxs_nxt;
      ack_r   <= ack_nxt;
      rd_r    <= rd_nxt;
      init_r  <= init_nxt;
      hlt_d_r <= ber_r[BER_HALT];
      rst_r   <= rst_nxt;
      rcnt_r  <= rcnt_nxt;
      rxc_r   <= rxc_nxt;
      txc_r   <= txc_nxt;
      rxp_r   <= rxp_nxt;
      sw_r    <= sw_nxt;
      st_r    <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign lnk.ack     = ack_r;
  assign lnk.rdata   = rd_r;
  assign lnk.err_irq = ber_r[BER_SUMMARY] & ien_r;
  // parity and write sequence faults refuse the transaction
  assign bus_noack   = ev_parity | ev_wr_seq;
  assign dm_status_wr = sw_r;
  assign dm_status   = st_r;
  assign cpu_halt    = ber_r[BER_HALT];
  // restart fires on the release of halt
  assign cpu_restart = hlt_d_r & ~ber_r[BER_HALT];
  assign cpu_restart_code = RESTART_CODE;
  assign cpu_boot_addr = BOOT_ADDR;
  assign cpu_err     = gto_r;
  assign cpu_nmi     = power_fail;
  assign lan_mem_err = mem_err;
  assign rx_partial  = rxp_r;
  assign tx_enable   = ~txs_r;
  assign rx_enable   = ~rxs_r;
  assign node_resetting = rst_r;
  assign port_init   = init_r;
  assign port_data_one = pd1_r;
  assign port_data_two = pd2_r;
endmodule

//--- rtl/abec_host.sv
`timescale 1ns/1ps
module abec_host
  import abec_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  abec_if.hst              lnk,
  output logic             err_irq
);
  import abec_pkg::*;

  typedef enum logic {H_IDLE, H_XFER} abec_hst_e;

  // ----------------------------------------------------------------
  // sequence table: {last, we, addr, data}
  // ----------------------------------------------------------------
  function automatic logic [36:0] step_fn(input abec_op_e op, input logic [2:0] s,
                                          input logic [36:0] raw,
                                          input logic [31:0] p1, input logic [31:0] p2);
    logic [36:0] r;
    logic [31:0] hb;
    logic [31:0] rb;
    hb = '0;
    rb = '0;
    hb[BER_HALT] = 1'b1;
    rb[BER_NRESET] = 1'b1;
    r = raw;
    case (op)
      OP_RAW:    r = raw;
      // halt set, halt clear, then full port init
      OP_HALT:   case (s)
                   3'h0:    r = {2'b01, IDX_BER, hb};
                   3'h1:    r = {2'b01, IDX_BER, 32'h0};
                   3'h2:    r = {2'b01, IDX_PD1, p1};
                   3'h3:    r = {2'b01, IDX_PD2, p2};
                   default: r = {2'b11, IDX_PINIT, 32'h0};
                 endcase
      OP_NRESET: case (s)
                   3'h0:    r = {2'b01, IDX_BER, rb};
                   3'h1:    r = {2'b01, IDX_PD1, p1};
                   3'h2:    r = {2'b01, IDX_PD2, p2};
                   default: r = {2'b11, IDX_PINIT, 32'h0};
                 endcase
      default:   case (s)
                   3'h0:    r = {2'b01, IDX_PD1, p1};
                   3'h1:    r = {2'b01, IDX_PD2, p2};
                   default: r = {2'b11, IDX_PINIT, 32'h0};
                 endcase
    endcase
    return r;
  endfunction

  abec_hst_e   st_r,   st_nxt;
  abec_op_e    op_r,   op_nxt;
  logic [2:0]  stp_r,  stp_nxt;
  logic [2:0]  ad_r,   ad_nxt;
  logic        we_r,   we_nxt;
  logic [31:0] wd_r,   wd_nxt;
  logic [31:0] rd_r,   rd_nxt;
  logic [31:0] p1_r,   p1_nxt;
  logic [31:0] p2_r,   p2_nxt;
  logic [31:0] prd_r,  prd_nxt;
  logic [36:0] cur;
  logic        acc;
  logic        hit;

  assign acc = psel & penable;
  assign hit = (paddr == HA_CMD) | (paddr == HA_WDATA) | (paddr == HA_RDATA) |
               (paddr == HA_STAT) | (paddr == HA_PD1) | (paddr == HA_PD2);
  assign cur = step_fn(op_r, stp_r, {1'b1, we_r, ad_r, wd_r}, p1_r, p2_r);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt  = st_r;
    op_nxt  = op_r;
    stp_nxt = stp_r;
    ad_nxt  = ad_r;
    we_nxt  = we_r;
    wd_nxt  = wd_r;
    rd_nxt  = rd_r;
    p1_nxt  = p1_r;
    p2_nxt  = p2_r;
    prd_nxt = prd_r;
    case (paddr)
      HA_CMD:   prd_nxt = {26'h0, op_r, we_r, ad_r};
      HA_WDATA: prd_nxt = wd_r;
      HA_RDATA: prd_nxt = rd_r;
      HA_STAT:  prd_nxt = {30'h0, lnk.err_irq, st_r == H_XFER};
      HA_PD1:   prd_nxt = p1_r;
      HA_PD2:   prd_nxt = p2_r;
      default:  prd_nxt = 32'h0;
    endcase
    if (acc & pwrite) begin
      case (paddr)
        HA_WDATA: wd_nxt = pwdata;
        HA_PD1:   p1_nxt = pwdata;
        HA_PD2:   p2_nxt = pwdata;
        HA_CMD:
          // a command while busy is dropped
          if (st_r == H_IDLE) begin
            ad_nxt  = pwdata[2:0];
            we_nxt  = pwdata[3];
            op_nxt  = abec_op_e'(pwdata[5:4]);
            stp_nxt = '0;
            st_nxt  = H_XFER;
          end
        default: ;
      endcase
    end
    case (st_r)
      H_IDLE: ;
      H_XFER:
        if (lnk.ack) begin
          if (!cur[35]) rd_nxt = lnk.rdata;
          stp_nxt = stp_r + 3'h1;
          if (cur[36]) st_nxt = H_IDLE;
        end
      default: st_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r  <= H_IDLE;
      op_r  <= OP_RAW;
      stp_r <= '0;
      ad_r  <= '0;
      we_r  <= 1'b0;
      wd_r  <= '0;
      rd_r  <= '0;
      p1_r  <= '0;
      p2_r  <= '0;
      prd_r <= '0;
    end else begin
      st_r  <= st_nxt;
      op_r  <= op_nxt;
      stp_r <= stp_nxt;
      ad_r  <= ad_nxt;
      we_r  <= we_nxt;
      wd_r  <= wd_nxt;
      rd_r  <= rd_nxt;
      p1_r  <= p1_nxt;
      p2_r  <= p2_nxt;
      prd_r <= prd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // read data is captured in setup, so the access can finish at once
  assign prdata    = prd_r;
  assign pready    = 1'b1;
  assign pslverr   = acc & ~hit;
  assign lnk.req   = (st_r == H_XFER) & ~lnk.ack;
  assign lnk.we    = cur[35];
  assign lnk.addr  = cur[34:32];
  assign lnk.wdata = cur[31:0];
  assign err_irq   = lnk.err_irq;
endmodule

//--- rtl/abec_if.sv
`timescale 1ns/1ps
interface abec_if;
  logic        req;
  logic        we;
  logic [2:0]  addr;
  logic [31:0] wdata;
  logic        ack;
  logic [31:0] rdata;
  logic        err_irq;

  modport dev (input req, input we, input addr, input wdata,
               output ack, output rdata, output err_irq);
  modport hst (output req, output we, output addr, output wdata,
               input ack, input rdata, input err_irq);
endinterface

//--- rtl/abec_pkg.sv
package abec_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS     = 20;
  localparam int RX_LAT_NS  = 21000;
  localparam int TX_LAT_NS  = 9000;
  localparam int RX_LAT_CYC = RX_LAT_NS / CLK_NS;
  localparam int TX_LAT_CYC = TX_LAT_NS / CLK_NS;
  localparam int RESET_CYC  = 16;

  // ----------------------------------------------------------------
  // device register indices on the link
  // ----------------------------------------------------------------
  localparam logic [2:0] IDX_BER   = 3'h0;
  localparam logic [2:0] IDX_PINIT = 3'h1;
  localparam logic [2:0] IDX_PD1   = 3'h2;
  localparam logic [2:0] IDX_PD2   = 3'h3;
  localparam logic [2:0] IDX_DIAG  = 3'h4;
  localparam logic [2:0] IDX_CTRL  = 3'h5;

  // bus error register fields
  localparam int BER_SUMMARY = 31;
  localparam int BER_HALT    = 29;
  localparam int BER_NRESET  = 28;
  localparam int BER_PAR     = 23;
  localparam int BER_WSEQ    = 22;
  localparam int BER_RDNAK   = 21;
  localparam int BER_WDNAK   = 20;
  localparam int BER_NORSP   = 18;
  localparam int BER_RSEQ    = 17;
  localparam int BER_RERSP   = 16;
  localparam int BER_CMDNAK  = 15;
  localparam int BER_TMO     = 13;
  localparam logic [31:0] BER_FLAGS = 32'h00f7_a000;
  localparam logic [31:0] BER_RESET = 32'h0000_0000;

  // diag register fields
  localparam int DIAG_GNT_TMO = 0;
  localparam int DIAG_TX_STOP = 1;
  localparam int DIAG_RX_STOP = 2;

  // error status codes posted to the datamove / peek register
  localparam logic [3:0] ST_NORSP  = 4'h1;
  localparam logic [3:0] ST_RERSP  = 4'h2;
  localparam logic [3:0] ST_CMDNAK = 4'h3;
  localparam logic [3:0] ST_TMO    = 4'h4;

  // restart of the embedded processor after a node halt
  localparam logic [7:0]  RESTART_CODE = 8'h02;
  localparam logic [31:0] BOOT_ADDR    = 32'h2004_0000;

  // ----------------------------------------------------------------
  // host controller map (apb byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] HA_CMD   = 8'h00;
  localparam logic [7:0] HA_WDATA = 8'h04;
  localparam logic [7:0] HA_RDATA = 8'h08;
  localparam logic [7:0] HA_STAT  = 8'h0c;
  localparam logic [7:0] HA_PD1   = 8'h10;
  localparam logic [7:0] HA_PD2   = 8'h14;

  typedef enum logic [1:0] {OP_RAW, OP_HALT, OP_NRESET, OP_INIT} abec_op_e;
endpackage
